/* File: logic/tx_cell_error_and_fill_gen.sv */
/*
 * transmit cell stage: passes cells from the transmit fifo toward the
 * framer, builds fill cells when no cell is ready, and corrupts the
 * check byte of chosen cells at a programmed rate or on a manual pin.
 * assumes a first-word-fall-through fifo on the same clock, a framer that
 * pulls one byte per take strobe, and an 8-bit register port.
 */
// The plain strobed port is this design's own decision.
`timescale 1ns/10ps
`include "txc_map.svh"

module tx_cell_error_and_fill_gen
	import txc_pkg::*;
(
	// clock and reset
	input wire logic mclk_i,
	input wire logic reset_i,
	// register port
	input wire logic [15:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	// manual error pin
	input wire logic manual_error_input_i,
	// transmit fifo side
	input wire logic fifo_cell_avail_i,
	input wire logic [7:0] fifo_data_i,
	output logic fifo_rd_o,
	// framer side
	input wire logic framer_take_i,
	output logic [7:0] cell_data_o,
	output logic cell_valid_o,
	output logic cell_start_o,
	output logic cell_errored_o
);

	// ============================================================
	// register storage
	logic [7:0] cell_proc_control_q; // fill selects
	logic [7:0] error_count_field_q; // errored cells per run
	logic [7:0] error_rate_and_manual_select_q; // manual select and rate
	logic [7:0] hec_error_mask_q; // check byte inversion mask
	logic [7:0] fill_header_byte0_q; // header bits 7:0
	logic [7:0] fill_header_byte1_q; // header bits 15:8
	logic [7:0] fill_header_byte2_q; // header bits 23:16
	logic [7:0] fill_header_byte3_q; // header bits 31:24
	logic [7:0] fill_payload_byte_q; // fill payload pattern
	logic [7:0] rdata_q; // read data, valid one cycle
	logic [7:0] rdata_d;

	// decoded fields
	logic fill_header_select;
	logic fill_payload_select;
	logic manual_insert_select;
	logic [2:0] exp_field;
	logic [2:0] exp_used;
	logic [3:0] mantissa;
	logic [31:0] fill_header_pattern;
	logic [31:0] header_word; // header sent in fill cells
	logic [7:0] fill_payload_pattern;
	logic mask_live;

	// run control
	run_state_t run_q; // insertion run state
	logic [7:0] sent_q; // errored cells sent in this run
	logic insertion_finished_q; // finished status
	logic ctrl_wr; // write to either errored-cell control byte
	logic run_start; // write that starts a fresh run
	logic [23:0] period; // cells per errored cell
	logic [23:0] pow10; // ten to the used exponent
	logic spacing_hit; // spacing counter closes a period

	// manual path
	logic manual_rise; // settled rising edge of the pin
	logic manual_pend_q; // an edge waits for the next cell

	// cell stream
	logic [5:0] idx_q; // byte index within the cell
	cell_src_t src_q; // source of the current cell
	cell_src_t src_now; // source for the byte now taken
	logic cell_begin; // first byte of a cell is taken
	logic rate_err; // rate path errors this cell
	logic err_now; // this cell is errored
	logic errored_q; // current cell is errored
	logic errored_now; // errored state for the byte now taken
	logic [7:0] byte_d; // byte to present next
	logic [7:0] data_q;
	logic valid_q;
	logic start_q;
	logic errflag_q;

	// ============================================================
	// field decode
	assign fill_header_select = cell_proc_control_q[`TXC_BIT_FILL_HDR_SEL];
	assign fill_payload_select = cell_proc_control_q[`TXC_BIT_FILL_PAY_SEL];
	assign manual_insert_select = error_rate_and_manual_select_q[`TXC_BIT_MANUAL_SEL];
	assign exp_field = error_rate_and_manual_select_q[`TXC_EXP_HI:`TXC_EXP_LO];
	assign mantissa = error_rate_and_manual_select_q[`TXC_MANT_HI:`TXC_MANT_LO];
	// first byte register is the least significant byte
	assign fill_header_pattern = {fill_header_byte3_q, fill_header_byte2_q,
		fill_header_byte1_q, fill_header_byte0_q};
	assign fill_payload_pattern = fill_payload_byte_q;
	// a literal cannot be part-selected, so the idle header passes through a net
	assign header_word = fill_header_select ? fill_header_pattern : `TXC_IDLE_HEADER;
	assign mask_live = (hec_error_mask_q != `TXC_RST_BYTE);

	// exponent codes above six clamp to six
	assign exp_used = (exp_field > `TXC_EXP_MAX) ? `TXC_EXP_MAX : exp_field;

	// ============================================================
	// ten to the exponent
	always_comb begin
		unique case (exp_used)
			3'h0: pow10 = 24'd1;
			3'h1: pow10 = 24'd10;
			3'h2: pow10 = 24'd100;
			3'h3: pow10 = 24'd1000;
			3'h4: pow10 = 24'd10000;
			3'h5: pow10 = 24'd100000;
			default: pow10 = 24'd1000000;
		endcase
	end

	// spacing is mantissa times ten^exponent; 01h gives 1, 0Fh 15, 11h 10
	assign period = 24'(mantissa * pow10);

	// ============================================================
	// register writes
	assign ctrl_wr = reg_wr_i &&
		(reg_addr_i == `TXC_OFS_ERR_COUNT || reg_addr_i == `TXC_OFS_ERR_RATE);

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			cell_proc_control_q <= `TXC_RST_BYTE;
			error_count_field_q <= `TXC_RST_BYTE;
			error_rate_and_manual_select_q <= `TXC_RST_BYTE;
			hec_error_mask_q <= `TXC_RST_BYTE;
			fill_header_byte0_q <= `TXC_RST_BYTE;
			fill_header_byte1_q <= `TXC_RST_BYTE;
			fill_header_byte2_q <= `TXC_RST_BYTE;
			fill_header_byte3_q <= `TXC_RST_BYTE;
			fill_payload_byte_q <= `TXC_RST_BYTE;
		end else if (reg_wr_i) begin
			unique case (reg_addr_i)
				// only the two fill selects are held
				`TXC_OFS_CELL_CTRL: begin
					cell_proc_control_q <= reg_wdata_i & `TXC_CTRL_KEEP;
				end
				`TXC_OFS_ERR_COUNT: error_count_field_q <= reg_wdata_i;
				`TXC_OFS_ERR_RATE: error_rate_and_manual_select_q <= reg_wdata_i;
				`TXC_OFS_HEC_MASK: hec_error_mask_q <= reg_wdata_i;
				`TXC_OFS_HDR_B0: fill_header_byte0_q <= reg_wdata_i;
				`TXC_OFS_HDR_B1: fill_header_byte1_q <= reg_wdata_i;
				`TXC_OFS_HDR_B2: fill_header_byte2_q <= reg_wdata_i;
				`TXC_OFS_HDR_B3: fill_header_byte3_q <= reg_wdata_i;
				`TXC_OFS_FILL_PAY: fill_payload_byte_q <= reg_wdata_i;
				// unmapped writes are dropped
				default: begin
				end
			endcase
		end
	end

	// ============================================================
	// register reads, data stand only in the cycle after the strobe
	always_comb begin
		rdata_d = `TXC_RST_BYTE;
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				`TXC_OFS_CELL_CTRL: rdata_d = cell_proc_control_q;
				`TXC_OFS_ERR_COUNT: rdata_d = error_count_field_q;
				`TXC_OFS_ERR_RATE: rdata_d = error_rate_and_manual_select_q;
				`TXC_OFS_HEC_MASK: rdata_d = hec_error_mask_q;
				`TXC_OFS_HDR_B0: rdata_d = fill_header_byte0_q;
				`TXC_OFS_HDR_B1: rdata_d = fill_header_byte1_q;
				`TXC_OFS_HDR_B2: rdata_d = fill_header_byte2_q;
				`TXC_OFS_HDR_B3: rdata_d = fill_header_byte3_q;
				`TXC_OFS_FILL_PAY: rdata_d = fill_payload_byte_q;
				// status shows the finished flag in bit 0
				`TXC_OFS_STATUS: rdata_d = {7'h00, insertion_finished_q};
				// unmapped addresses read zero
				default: rdata_d = `TXC_RST_BYTE;
			endcase
		end
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			rdata_q <= `TXC_RST_BYTE;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata_o = rdata_q;

	// ============================================================
	// cell stream sequencing
	assign cell_begin = framer_take_i && (idx_q == 6'h00);
	// source is chosen on the first byte and held for the cell
	assign src_now = cell_begin ? (fifo_cell_avail_i ? SRC_FIFO : SRC_FILL) : src_q;
	assign fifo_rd_o = framer_take_i && (src_now == SRC_FIFO);

	// byte index advances per taken byte and wraps after the last
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			idx_q <= 6'h00;
			src_q <= SRC_FILL;
		end else if (framer_take_i) begin
			src_q <= src_now;
			idx_q <= (idx_q == `TXC_IDX_LAST) ? 6'h00 : idx_q + 6'h01;
		end
	end

	// ============================================================
	// manual error pin
	pin_rise_detect u_manual (
		.mclk_i(mclk_i),
		.reset_i(reset_i),
		.pin_i(manual_error_input_i),
		.rise_o(manual_rise)
	);

	// pending edge waits for the next cell; a new edge beats the clear
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			manual_pend_q <= 1'b0;
		end else if (manual_rise && manual_insert_select) begin
			manual_pend_q <= 1'b1;
		end else if (!manual_insert_select || cell_begin) begin
			manual_pend_q <= 1'b0;
		end
	end

	// ============================================================
	// rate spacing
	cell_spacing u_spacing (
		.mclk_i(mclk_i),
		.reset_i(reset_i),
		.clear_i(ctrl_wr),
		.step_i(cell_begin && (run_q == RUN_ACTIVE) && !ctrl_wr),
		.period_i(period),
		.hit_o(spacing_hit)
	);

	// rate and manual paths work side by side; zero mask blocks both
	assign rate_err = spacing_hit && mask_live;
	assign err_now = mask_live && (spacing_hit || manual_pend_q);

	// ============================================================
	// insertion run control
	// every control write restarts; the new state decides if the run is live
	assign run_start = ctrl_wr;

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			run_q <= RUN_IDLE;
			sent_q <= 8'h00;
			insertion_finished_q <= 1'b0;
		end else if (run_start) begin
			// any control write abandons the old run
			sent_q <= 8'h00;
			insertion_finished_q <= 1'b0;
			run_q <= next_run_state();
		end else if (run_q == RUN_ACTIVE && rate_err) begin
			sent_q <= sent_q + 8'h01;
			// all ones runs forever
			if (error_count_field_q != `TXC_COUNT_FOREVER &&
				sent_q + 8'h01 == error_count_field_q) begin
				run_q <= RUN_DONE;
				insertion_finished_q <= 1'b1;
			end
		end
	end

	// state after a control write, from the value it leaves behind
	function automatic run_state_t next_run_state();
		logic [7:0] rate_new;
		logic [7:0] count_new;
		rate_new = (reg_addr_i == `TXC_OFS_ERR_RATE) ? reg_wdata_i :
			error_rate_and_manual_select_q;
		count_new = (reg_addr_i == `TXC_OFS_ERR_COUNT) ? reg_wdata_i :
			error_count_field_q;
		if (rate_new[`TXC_MANT_HI:`TXC_MANT_LO] == 4'h0) begin
			next_run_state = RUN_IDLE;
		end else if (count_new == 8'h00) begin
			next_run_state = RUN_DONE;
		end else begin
			next_run_state = RUN_ACTIVE;
		end
	endfunction

	// ============================================================
	// errored flag for the current cell
	assign errored_now = cell_begin ? err_now : errored_q;

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			errored_q <= 1'b0;
		end else if (cell_begin) begin
			errored_q <= err_now;
		end
	end

	// ============================================================
	// byte selection
	always_comb begin
		byte_d = fifo_data_i;
		if (src_now == SRC_FILL) begin
			if (idx_q < `TXC_IDX_HEC) begin
				// header bytes, most significant first
				byte_d = header_word[8'(6'd31 - 6'(idx_q * 6'd8)) -: 8];
			end else if (idx_q == `TXC_IDX_HEC) begin
				byte_d = `TXC_FILL_HEC;
			end else if (fill_payload_select) begin
				byte_d = fill_payload_pattern;
			end else begin
				byte_d = `TXC_IDLE_PAYLOAD;
			end
		end
		if (idx_q == `TXC_IDX_HEC && errored_now) begin
			byte_d = byte_d ^ hec_error_mask_q;
		end
	end

	// ============================================================
	// output registers, one cycle after the take strobe
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			data_q <= `TXC_RST_BYTE;
			valid_q <= 1'b0;
			start_q <= 1'b0;
			errflag_q <= 1'b0;
		end else begin
			valid_q <= framer_take_i;
			start_q <= cell_begin;
			errflag_q <= framer_take_i && errored_now;
			if (framer_take_i) begin
				data_q <= byte_d;
			end
		end
	end

	assign cell_data_o = data_q;
	assign cell_valid_o = valid_q;
	assign cell_start_o = start_q;
	assign cell_errored_o = errflag_q;

endmodule // tx_cell_error_and_fill_gen

/* File: logic/txc_map.svh */
/*
 * register offsets, field positions, reset values and cell layout constants
 * for the transmit cell error and fill generator.
 * assumes an 8-bit register port with a 16-bit byte address.
 */
// ============================================================
// How it works
// - manual input ignored while manual select clear
// - manual select set: each rising edge errors one cell
// - rate insertion keeps running beside manual insertion
// - one errored cell every x times ten^y cells
// - exponent codes 6 and 7 both mean six
// - mantissa zero disables rate insertion
// - codes 01h, 0Fh, 11h give 1, 15, 10
// - control write with nonzero mantissa starts a run
// - control write mid-run abandons and restarts
// - run stops after programmed count of errored cells
// - errored cell inverts check bits where mask set
// - all-zero mask means no insertion at all
// - header select set: programmable header in fill cells
// - header pattern built from four bytes, low first
// - payload select set: programmable payload byte in fill
// - header select clear: idle header, payload untouched
// - payload select clear: idle payload byte 6Ah
// - count of all ones never ends the run
// - finished flag set at end, cleared on disable/restart
`ifndef TXC_MAP_SVH
`define TXC_MAP_SVH

// ============================================================
// register offsets
`define TXC_OFS_CELL_CTRL 16'h1100
`define TXC_OFS_ERR_COUNT 16'h1104
`define TXC_OFS_ERR_RATE 16'h1105
`define TXC_OFS_HEC_MASK 16'h1106
`define TXC_OFS_HDR_B0 16'h1108
`define TXC_OFS_HDR_B1 16'h1109
`define TXC_OFS_HDR_B2 16'h110a
`define TXC_OFS_HDR_B3 16'h110b
`define TXC_OFS_FILL_PAY 16'h110c
`define TXC_OFS_STATUS 16'h110e

// ============================================================
// field positions
`define TXC_BIT_FILL_HDR_SEL 5
`define TXC_BIT_FILL_PAY_SEL 4
`define TXC_BIT_MANUAL_SEL 7
`define TXC_EXP_HI 6
`define TXC_EXP_LO 4
`define TXC_MANT_HI 3
`define TXC_MANT_LO 0
`define TXC_BIT_FINISHED 0
`define TXC_CTRL_KEEP 8'h30

// ============================================================
// reset values and fixed codes
`define TXC_RST_BYTE 8'h00
`define TXC_COUNT_FOREVER 8'hff
`define TXC_EXP_MAX 3'h6
`define TXC_IDLE_HEADER 32'h00000001
`define TXC_IDLE_PAYLOAD 8'h6a
`define TXC_FILL_HEC 8'h00

// ============================================================
// cell layout: four header bytes, check byte, 48 payload bytes
`define TXC_IDX_HEC 6'h04
`define TXC_IDX_LAST 6'h34

`endif

/* File: logic/txc_pkg.sv */
/*
 * types shared by the transmit cell error and fill generator.
 * assumes txc_map.svh for the numeric constants.
 */
package txc_pkg;

	// ============================================================
	// rate-based insertion run state, gray along idle-run-done
	typedef enum logic [1:0] {
		RUN_IDLE = 2'b00,
		RUN_ACTIVE = 2'b01,
		RUN_DONE = 2'b11
	} run_state_t;

	// source of the cell now being sent
	typedef enum logic {
		SRC_FIFO = 1'b0,
		SRC_FILL = 1'b1
	} cell_src_t;

endpackage

/* File: logic/pin_rise_detect.sv */
/*
 * three-flop synchroniser with rising-edge detection for one pin.
 * assumes the pin is asynchronous to mclk_i.
 */
`timescale 1ns/10ps

module pin_rise_detect (
	// clock and reset
	input wire logic mclk_i,
	input wire logic reset_i,
	// asynchronous pin
	input wire logic pin_i,
	// one-cycle pulse on a settled low-to-high change
	output logic rise_o
);

	logic s1_q; // first stage, read only by s2_q
	logic s2_q; // second stage
	logic s3_q; // third stage
	logic level_q; // accepted level

	// ============================================================
	// synchroniser chain
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end else begin
			s1_q <= pin_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// a change counts once stages two and three agree
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			level_q <= 1'b0;
		end else if (s2_q == s3_q) begin
			level_q <= s3_q;
		end
	end

	assign rise_o = s2_q & s3_q & ~level_q;

endmodule // pin_rise_detect

/* File: logic/cell_spacing.sv */
/*
 * cell spacing counter: flags the cell that closes each period of cells.
 * assumes step_i pulses once per cell start and period_i is at least one.
 */
`timescale 1ns/10ps

module cell_spacing (
	// clock and reset
	input wire logic mclk_i,
	input wire logic reset_i,
	// control
	input wire logic clear_i,
	input wire logic step_i,
	input wire logic [23:0] period_i,
	// result
	output logic hit_o
);

	logic [23:0] count_q; // cells seen in the current period
	logic [23:0] last; // last count of a period

	assign last = period_i - 24'h000001;
	assign hit_o = step_i & (count_q == last);

	// ============================================================
	// count cells, wrap on the closing cell, clear on restart
	always_ff @(posedge mclk_i) begin
		if (reset_i || clear_i) begin
			count_q <= 24'h000000;
		end else if (hit_o) begin
			count_q <= 24'h000000;
		end else if (step_i) begin
			count_q <= count_q + 24'h000001;
		end
	end

endmodule // cell_spacing

/* File: sim/txc_fifo_model.sv */
/*
 * transmit fifo model: a fall-through head byte that counts up per pop.
 * assumes the bench raises ready_i only while a whole cell may be offered.
 */
`timescale 1ns/10ps

module txc_fifo_model (
	// clock and reset
	input wire logic mclk_i,
	input wire logic reset_i,
	// bench control and pop strobe
	input wire logic ready_i,
	input wire logic rd_i,
	// fifo outputs
	output logic cell_avail_o,
	output logic [7:0] data_o
);
	logic [7:0] cnt_q; // next byte to hand out

	// ============================================================
	// head byte advances once per pop
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			cnt_q <= 8'h00;
		end else if (rd_i) begin
			cnt_q <= cnt_q + 8'h01;
		end
	end

	// a cell is offered only while the bench allows it
	assign cell_avail_o = ready_i;
	// idle head shows the inverse so a stale byte never looks valid
	assign data_o = ready_i ? cnt_q : ~cnt_q;
endmodule // txc_fifo_model

/* File: sim/txc_monitor.sv */
/*
 * port checker for the transmit cell stage.
 * assumes it is bound onto tx_cell_error_and_fill_gen.
 */
`timescale 1ns/10ps
`include "txc_map.svh"

module txc_monitor (
	// clock and reset
	input wire logic mclk_i,
	input wire logic reset_i,
	// register port
	input wire logic [15:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	// cell stream
	input wire logic framer_take_i,
	input wire logic fifo_rd_o,
	input wire logic cell_valid_o,
	input wire logic cell_start_o,
	input wire logic cell_errored_o
);
	logic [7:0] mask_q; // shadow of the check byte mask
	logic err_q; // errored flag of the cell in flight

	default clocking @(posedge mclk_i); endclocking
	default disable iff (reset_i);

	// ============================================================
	// mask shadow from register writes
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			mask_q <= 8'h00;
		end else if (reg_wr_i && reg_addr_i == `TXC_OFS_HEC_MASK) begin
			mask_q <= reg_wdata_i;
		end
	end

	// errored flag of the last byte seen
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			err_q <= 1'b0;
		end else if (cell_valid_o) begin
			err_q <= cell_errored_o;
		end
	end

	// ============================================================
	// assertions
	AST_VALID_AFTER_TAKE: assert property (framer_take_i |=> cell_valid_o)
		else $error("no byte after take");
	AST_NO_SPURIOUS_VALID: assert property (!framer_take_i |=> !cell_valid_o)
		else $error("byte without take");
	AST_RDATA_IDLE_ZERO: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
		else $error("read data outside read slot");
	AST_STATUS_UPPER_ZERO:
		assert property (reg_rd_i && reg_addr_i == `TXC_OFS_STATUS |=> reg_rdata_o[7:1] == 7'h00)
		else $error("status upper bits set");
	AST_START_WITH_VALID: assert property (cell_start_o |-> cell_valid_o)
		else $error("start without byte");
	AST_POP_NEEDS_TAKE: assert property (fifo_rd_o |-> framer_take_i)
		else $error("pop without take");
	AST_ERROR_WHOLE_CELL:
		assert property (cell_valid_o && !cell_start_o |-> cell_errored_o == err_q)
		else $error("errored flag changed inside cell");
	AST_NO_ERROR_WITHOUT_MASK:
		assert property (cell_start_o && cell_errored_o |-> mask_q != 8'h00)
		else $error("errored cell with empty mask");
endmodule // txc_monitor

bind tx_cell_error_and_fill_gen txc_monitor u_txc_monitor (
	.mclk_i(mclk_i),
	.reset_i(reset_i),
	.reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i),
	.reg_wr_i(reg_wr_i),
	.reg_rd_i(reg_rd_i),
	.reg_rdata_o(reg_rdata_o),
	.framer_take_i(framer_take_i),
	.fifo_rd_o(fifo_rd_o),
	.cell_valid_o(cell_valid_o),
	.cell_start_o(cell_start_o),
	.cell_errored_o(cell_errored_o)
);

/* File: sim/test_tx_cell_error_and_fill_gen.sv */
/*
 * self-checking bench for the transmit cell stage; the bench acts as framer
 * and register master. assumes txc_fifo_model on the fifo side.
 */
`timescale 1ns/10ps
`include "txc_map.svh"

module test_tx_cell_error_and_fill_gen;
	logic mclk_i, reset_i, reg_wr_i, reg_rd_i, manual_error_input_i, framer_take_i, fifo_ready;
	logic [15:0] reg_addr_i;
	logic [7:0] reg_wdata_i, reg_rdata_o, fifo_data_i, cell_data_o;
	logic fifo_cell_avail_i, fifo_rd_o, cell_valid_o, cell_start_o, cell_errored_o;
	logic [7:0] byts [0:52]; // bytes of the last cell
	int errs, miscompares, tests_run, cyc;

	tx_cell_error_and_fill_gen u_tx_cell_error_and_fill_gen (.mclk_i(mclk_i),
		.reset_i(reset_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
		.manual_error_input_i(manual_error_input_i), .fifo_cell_avail_i(fifo_cell_avail_i),
		.fifo_data_i(fifo_data_i), .fifo_rd_o(fifo_rd_o), .framer_take_i(framer_take_i),
		.cell_data_o(cell_data_o), .cell_valid_o(cell_valid_o),
		.cell_start_o(cell_start_o), .cell_errored_o(cell_errored_o));
	txc_fifo_model u_txc_fifo_model (.mclk_i(mclk_i), .reset_i(reset_i),
		.ready_i(fifo_ready), .rd_i(fifo_rd_o), .cell_avail_o(fifo_cell_avail_i),
		.data_o(fifo_data_i));

	// ============================================================
	// helpers
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task finish_test;
		if (miscompares == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge mclk_i);
		reg_wr_i <= 1'b0;
	endtask

	task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
		@(posedge mclk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge mclk_i);
		reg_rd_i <= 1'b0;
		#1;
		check(reg_rdata_o, exp);
	endtask

	// takes n whole cells back to back, counts errored ones
	task automatic run_cells(input int n);
		int j;
		errs = 0;
		@(posedge mclk_i);
		framer_take_i <= 1'b1;
		for (j = 0; j < 53 * n; j++) begin
			@(posedge mclk_i);
			if (j == 53 * n - 1) begin
				framer_take_i <= 1'b0;
			end
			#1;
			byts[j % 53] = cell_data_o;
			check({6'h00, cell_valid_o, cell_start_o}, {6'h00, 1'b1, (j % 53) == 0});
			if (cell_start_o === 1'b1 && cell_errored_o === 1'b1) begin
				errs++;
			end
		end
	endtask

	task automatic chk_cell(input logic [31:0] h, input logic [7:0] p, input logic [7:0] hec);
		int i;
		for (i = 0; i < 4; i++) check(byts[i], h[8 * (3 - i) +: 8]);
		check(byts[4], hec);
		for (i = 5; i < 53; i++) check(byts[i], p);
	endtask

	task automatic pulse;
		@(posedge mclk_i);
		manual_error_input_i <= 1'b1;
		repeat (6) @(posedge mclk_i);
		manual_error_input_i <= 1'b0;
		repeat (6) @(posedge mclk_i);
	endtask

	// ============================================================
	// scenarios
	task automatic t_regs;
		logic [15:0] a [6] = '{16'h1106, 16'h1108, 16'h1109, 16'h110a, 16'h110b, 16'h110c};
		logic [7:0] v [6] = '{8'h5a, 8'h11, 8'h22, 8'h33, 8'h44, 8'ha5};
		int i;
		for (i = 0; i < 6; i++) rdc(a[i], 8'h00);
		rdc(`TXC_OFS_STATUS, 8'h00);
		for (i = 0; i < 6; i++) begin
			wr(a[i], v[i]);
			rdc(a[i], v[i]);
		end
		wr(16'h1107, 8'hff);
		rdc(16'h1107, 8'h00);
		wr(`TXC_OFS_CELL_CTRL, 8'hff);
		rdc(`TXC_OFS_CELL_CTRL, 8'h30);
	endtask

	task automatic t_fill;
		run_cells(1);
		chk_cell(32'h44332211, 8'ha5, `TXC_FILL_HEC);
		wr(`TXC_OFS_CELL_CTRL, 8'h20);
		run_cells(1);
		chk_cell(32'h44332211, `TXC_IDLE_PAYLOAD, `TXC_FILL_HEC);
		wr(`TXC_OFS_CELL_CTRL, 8'h10);
		run_cells(1);
		chk_cell(`TXC_IDLE_HEADER, 8'ha5, `TXC_FILL_HEC);
		wr(`TXC_OFS_CELL_CTRL, 8'h00);
	endtask

	task automatic t_rate;
		logic [7:0] code [9] = '{8'h01, 8'h11, 8'h0f, 8'h00, 8'h61, 8'h71, 8'h01, 8'h01, 8'h01};
		logic [7:0] cnt [9] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'h03};
		int n [9] = '{3, 30, 30, 3, 3, 3, 3, 2, 5};
		int e [9] = '{3, 3, 2, 0, 0, 0, 3, 0, 3};
		int i;
		for (i = 0; i < 9; i++) begin
			wr(`TXC_OFS_ERR_COUNT, cnt[i]);
			wr(`TXC_OFS_ERR_RATE, code[i]);
			run_cells(n[i]);
			check(errs[7:0], e[i][7:0]);
		end
		check(byts[4], `TXC_FILL_HEC);
		rdc(`TXC_OFS_STATUS, 8'h01);
		wr(`TXC_OFS_ERR_RATE, 8'h01);
		rdc(`TXC_OFS_STATUS, 8'h00);
		run_cells(1);
		check(errs[7:0], 8'h01);
		check(byts[4], 8'h5a);
		wr(`TXC_OFS_ERR_COUNT, 8'h03);
		run_cells(4);
		check(errs[7:0], 8'h03);
		// all-ones count must outlast 255 errored cells
		wr(`TXC_OFS_ERR_COUNT, `TXC_COUNT_FOREVER);
		run_cells(257);
		check(errs[15:8], 8'h01);
		check(errs[7:0], 8'h01);
	endtask

	task automatic t_mask_manual;
		wr(`TXC_OFS_HEC_MASK, 8'h00);
		wr(`TXC_OFS_ERR_COUNT, 8'hff);
		wr(`TXC_OFS_ERR_RATE, 8'h01);
		run_cells(2);
		check(errs[7:0], 8'h00);
		wr(`TXC_OFS_HEC_MASK, 8'h5a);
		wr(`TXC_OFS_ERR_RATE, 8'h00);
		pulse();
		run_cells(2);
		check(errs[7:0], 8'h00);
		wr(`TXC_OFS_ERR_RATE, 8'h80);
		pulse();
		run_cells(2);
		check(errs[7:0], 8'h01);
		wr(`TXC_OFS_ERR_COUNT, 8'h02);
		wr(`TXC_OFS_ERR_RATE, 8'h81);
		run_cells(4);
		check(errs[7:0], 8'h02);
		wr(`TXC_OFS_ERR_RATE, 8'h00);
	endtask

	task automatic t_fifo;
		int i;
		@(posedge mclk_i);
		fifo_ready <= 1'b1;
		run_cells(1);
		fifo_ready <= 1'b0;
		for (i = 0; i < 53; i++) check(byts[i], i[7:0]);
		check(errs[7:0], 8'h00);
	endtask

	// ============================================================
	// clock, watchdog and main sequence
	initial begin
		mclk_i = 1'b0;
		forever #20 mclk_i = ~mclk_i;
	end

	// cut a hang short
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 40000) begin
			miscompares++;
			finish_test();
		end
	end

	initial begin
		{reg_wr_i, reg_rd_i, manual_error_input_i, framer_take_i, fifo_ready} = 5'h00;
		{reg_addr_i, reg_wdata_i} = 24'h000000;
		miscompares = 0;
		tests_run = 0;
		cyc = 0;
		reset_i = 1'b1;
		repeat (4) @(posedge mclk_i);
		reset_i <= 1'b0;
		t_regs();
		t_fill();
		t_rate();
		t_mask_manual();
		t_fifo();
		finish_test();
	end
endmodule // test_tx_cell_error_and_fill_gen
